// File: hw/ata_set_features.sv
// Set-features decoder, security word and identify word substitution
`timescale 1ns/10ps

// Functional notes
// - Opcode EFH runs the feature op named by feature; parameter in count.
// - Feature 01H turns eight-bit transfers on, 81H turns them off.
// - Eight-bit mode: low byte lanes only, IOCS16 not asserted.
// - Feature 02H enables write cache, 82H disables it, if implemented.
// - Disabling write cache flushes it before the command completes.
// - Feature 03H: count bits 7:3 give type, bits 2:0 give mode.
// - Types: PIO default, PIO no IORDY, flow PIO, MW DMA, UDMA.
// - Mode number of flow PIO and DMA types beyond range is invalid.
// - Exactly one PIO mode always selected; modes changeable any time.
// - Feature 05H enables power management, 85H disables it.
// - Feature 09H enables extended power ops, 89H disables them.
// - Read look-ahead off by default; AAH enables, 55H disables.
// - 66H keeps settings over soft reset; CCH restores defaults again.
// - Features 69H, 96H, 97H accepted with no effect.
// - Security word bit 0 support, bit 1 enabled.
// - Security word bit 2 locked, bit 3 frozen.
// - Bit 4 expired count; unlock and erase abort until hard reset.
// - Security word bit 5 shows enhanced erase support.
// - Security word bit 8 is level when enabled: one is maximum.
// - Rotation rate word always reads 0001H.
// - Integrity word: A5h low, checksum of all bytes high.
module ata_set_features #(
  parameter logic [2:0] MAX_PIO_MODE    = 3'h4,
  parameter logic [2:0] MAX_MWDMA_MODE  = 3'h2,
  parameter logic [2:0] MAX_UDMA_MODE   = 3'h6,
  parameter bit         HAS_WRITE_CACHE = 1'b1,
  parameter logic [3:0] UNLOCK_TRIES    = 4'h5
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                soft_rst,
  input  wire logic                cmd_valid,
  input  wire ata_feat_pkg::cmd_s  cmd,
  input  wire logic                flush_ack,
  input  wire ata_feat_pkg::sec_s  sec_state,
  input  wire logic                unlock_fail,
  input  wire logic                unlock_cmd,
  input  wire logic                erase_cmd,
  input  wire logic                id_valid,
  input  wire logic [7:0]          id_index,
  input  wire logic [15:0]         id_word,
  output logic                     busy,
  output logic                     cmd_done,
  output logic                     cmd_abort,
  output logic                     err_abrt,
  output logic                     flush_req,
  output ata_feat_pkg::cfg_s       cfg,
  output logic                     iocs16_en,
  output logic                     sec_expired,
  output logic                     id_out_valid,
  output logic [7:0]               id_out_index,
  output logic [15:0]              id_out_word
);

  ata_feat_pkg::state_e state;
  ata_feat_pkg::state_e next_state;
  ata_feat_pkg::cfg_s   dec_cfg;
  ata_feat_pkg::cfg_s   next_cfg;
  logic                 dec_ok;
  logic                 dec_flush;
  logic                 accept;
  logic [4:0]           xtype;
  logic [2:0]           xmode;
  logic                 sec_abort;
  logic [3:0]           fail_count;
  logic [15:0]          sec_word;
  logic [15:0]          next_word;
  logic [7:0]           csum;

  assign accept = cmd_valid && !soft_rst &&
                  (state == ata_feat_pkg::ST_IDLE) &&
                  (cmd.opcode == ata_feat_pkg::OP_SET_FEATURES);
  assign xtype = cmd.count[7:ata_feat_pkg::XFER_TYPE_LSB];
  assign xmode = cmd.count[2:0];
  // refuse unlock and erase once expired
  assign sec_abort = sec_expired && !soft_rst &&
                     (state == ata_feat_pkg::ST_IDLE) &&
                     (unlock_cmd || erase_cmd);

  // ----------------------------------------------------------------
  // Feature decode
  // ----------------------------------------------------------------
  always_comb begin
    dec_cfg   = cfg;
    dec_ok    = 1'b1;
    dec_flush = 1'b0;
    case (cmd.feature)
      ata_feat_pkg::FC_8BIT_ON:  dec_cfg.eight_bit = 1'b1;
      ata_feat_pkg::FC_8BIT_OFF: dec_cfg.eight_bit = 1'b0;
      ata_feat_pkg::FC_WCACHE_ON: begin
        dec_cfg.write_cache = HAS_WRITE_CACHE;
        dec_ok              = HAS_WRITE_CACHE;
      end
      ata_feat_pkg::FC_WCACHE_OFF: begin
        dec_cfg.write_cache = 1'b0;
        dec_ok              = HAS_WRITE_CACHE;
        // flush only if dirty data may exist
        dec_flush           = HAS_WRITE_CACHE && cfg.write_cache;
      end
      ata_feat_pkg::FC_XFER_MODE: begin
        case (xtype)
          ata_feat_pkg::XT_PIO_DEFAULT: begin
            dec_cfg.pio_mode = 3'h0;
            if (xmode == ata_feat_pkg::MODE_DEFAULT) begin
              dec_cfg.iordy_off = 1'b0;
            end else if (xmode == ata_feat_pkg::MODE_NO_IORDY) begin
              dec_cfg.iordy_off = 1'b1;
            end else begin
              dec_ok = 1'b0;
            end
          end
          ata_feat_pkg::XT_PIO_FLOW: begin
            dec_cfg.pio_mode  = xmode;
            dec_cfg.iordy_off = 1'b0;
            dec_ok            = (xmode <= MAX_PIO_MODE);
          end
          ata_feat_pkg::XT_MWDMA: begin
            dec_cfg.dma_kind = ata_feat_pkg::DMA_MWDMA;
            dec_cfg.dma_mode = xmode;
            dec_ok           = (xmode <= MAX_MWDMA_MODE);
          end
          ata_feat_pkg::XT_UDMA: begin
            dec_cfg.dma_kind = ata_feat_pkg::DMA_UDMA;
            dec_cfg.dma_mode = xmode;
            dec_ok           = (xmode <= MAX_UDMA_MODE);
          end
          default: dec_ok = 1'b0;
        endcase
      end
      ata_feat_pkg::FC_APM_ON:  dec_cfg.apm = 1'b1;
      ata_feat_pkg::FC_APM_OFF: dec_cfg.apm = 1'b0;
      ata_feat_pkg::FC_EXTPWR_ON:  dec_cfg.ext_power = 1'b1;
      ata_feat_pkg::FC_EXTPWR_OFF: dec_cfg.ext_power = 1'b0;
      ata_feat_pkg::FC_LOOKAHEAD_ON:  dec_cfg.read_ahead = 1'b1;
      ata_feat_pkg::FC_LOOKAHEAD_OFF: dec_cfg.read_ahead = 1'b0;
      ata_feat_pkg::FC_KEEP_ON_SRST: dec_cfg.keep_on_srst = 1'b1;
      ata_feat_pkg::FC_RESTORE_SRST: dec_cfg.keep_on_srst = 1'b0;
      ata_feat_pkg::FC_NOP_A,
      ata_feat_pkg::FC_NOP_B,
      ata_feat_pkg::FC_LEGACY: dec_ok = 1'b1;
      default: dec_ok = 1'b0;
    endcase
    // Rejected command leaves every setting untouched
    if (!dec_ok) begin
      dec_cfg   = cfg;
      dec_flush = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  always_comb begin
    next_cfg = cfg;
    if (soft_rst && !cfg.keep_on_srst) begin
      next_cfg = ata_feat_pkg::CFG_POR;
    end else if (accept) begin
      next_cfg = dec_cfg;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg       <= ata_feat_pkg::CFG_POR;
      iocs16_en <= 1'b1;
    end else begin
      cfg       <= next_cfg;
      // no 16-bit data cycles in eight-bit mode
      iocs16_en <= !next_cfg.eight_bit;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ata_feat_pkg::ST_IDLE: begin
        if (accept && dec_flush) begin
          next_state = ata_feat_pkg::ST_FLUSH;
        end
      end
      ata_feat_pkg::ST_FLUSH: begin
        if (flush_ack) begin
          next_state = ata_feat_pkg::ST_IDLE;
        end
      end
      default: next_state = ata_feat_pkg::ST_IDLE;
    endcase
    // Soft reset abandons a flush in progress
    if (soft_rst) begin
      next_state = ata_feat_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state     <= ata_feat_pkg::ST_IDLE;
      busy      <= 1'b0;
      flush_req <= 1'b0;
    end else begin
      state     <= next_state;
      busy      <= (next_state == ata_feat_pkg::ST_FLUSH);
      flush_req <= (next_state == ata_feat_pkg::ST_FLUSH);
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_done  <= 1'b0;
      cmd_abort <= 1'b0;
    end else begin
      cmd_done  <= (accept && dec_ok && !dec_flush) ||
                   (state == ata_feat_pkg::ST_FLUSH && flush_ack &&
                    !soft_rst);
      cmd_abort <= (accept && !dec_ok) || sec_abort;
    end
  end
  // Error flag: a new abort wins over the clear by the next command
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_abrt <= 1'b0;
    end else if ((accept && !dec_ok) || sec_abort) begin
      err_abrt <= 1'b1;
    end else if (accept || soft_rst) begin
      err_abrt <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Unlock attempt counter
  // ----------------------------------------------------------------
  // only power-on or hard reset clears expiry
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fail_count  <= 4'h0;
      sec_expired <= 1'b0;
    end else if (unlock_fail && !sec_expired) begin
      fail_count <= fail_count + 4'h1;
      if (fail_count + 4'h1 >= UNLOCK_TRIES) begin
        sec_expired <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Identify word substitution
  // ----------------------------------------------------------------
  always_comb begin
    sec_word = 16'h0000;
    sec_word[ata_feat_pkg::SEC_BIT_SUPPORT] = sec_state.supported;
    sec_word[ata_feat_pkg::SEC_BIT_ENABLED] = sec_state.enabled;
    sec_word[ata_feat_pkg::SEC_BIT_LOCKED]  = sec_state.locked;
    sec_word[ata_feat_pkg::SEC_BIT_FROZEN]  = sec_state.frozen;
    sec_word[ata_feat_pkg::SEC_BIT_EXPIRED] = sec_expired;
    sec_word[ata_feat_pkg::SEC_BIT_ENH]     = sec_state.enh_erase;
    sec_word[ata_feat_pkg::SEC_BIT_LEVEL]   = sec_state.enabled &&
                                              sec_state.level_max;
  end
  always_comb begin
    case (id_index)
      ata_feat_pkg::ID_WORD_SECURITY: next_word = sec_word;
      ata_feat_pkg::ID_WORD_ROTATION:
        next_word = ata_feat_pkg::ROTATION_NONROT;
      ata_feat_pkg::ID_WORD_INTEGRITY:
        next_word = {csum, ata_feat_pkg::ID_SIGNATURE};
      default: next_word = id_word;
    endcase
  end

  // Sums the words as sent, so substituted words are covered too
  idw_checksum u_checksum (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .word_valid (id_valid),
    .word_index (id_index),
    .word_data  (next_word),
    .csum       (csum)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      id_out_valid <= 1'b0;
      id_out_index <= 8'h00;
      id_out_word  <= 16'h0000;
    end else begin
      id_out_valid <= id_valid;
      id_out_index <= id_index;
      id_out_word  <= next_word;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_eight_on: assert property (@(posedge sys_clk) disable iff (rst)
    accept && cmd.feature == ata_feat_pkg::FC_8BIT_ON && !soft_rst
    |=> cfg.eight_bit && !iocs16_en && cmd_done)
    else $error("eight-bit mode not entered");
  a_iocs16_lane: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.eight_bit |-> !iocs16_en)
    else $error("IOCS16 allowed in eight-bit mode");
  a_flush_hold: assert property (@(posedge sys_clk) disable iff (rst)
    accept && dec_flush ##1 (!flush_ack && !soft_rst)[*2]
    |-> busy && flush_req && !cmd_done)
    else $error("write cache command ended before flush");
  a_udma_select: assert property (@(posedge sys_clk) disable iff (rst)
    accept && cmd.feature == ata_feat_pkg::FC_XFER_MODE &&
    xtype == ata_feat_pkg::XT_UDMA && xmode <= MAX_UDMA_MODE
    |=> cfg.dma_kind == ata_feat_pkg::DMA_UDMA &&
        cfg.dma_mode == $past(xmode))
    else $error("ultra DMA mode not selected");
  a_pio_range: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.pio_mode <= MAX_PIO_MODE)
    else $error("PIO mode out of range");
  a_bad_feature: assert property (@(posedge sys_clk) disable iff (rst)
    accept && !dec_ok |=> cmd_abort && err_abrt && !cmd_done &&
                          cfg == $past(cfg))
    else $error("bad feature not aborted");
  a_keep_srst: assert property (@(posedge sys_clk) disable iff (rst)
    soft_rst && cfg.keep_on_srst |=> cfg == $past(cfg))
    else $error("settings lost over soft reset");
  a_expire_abort: assert property (@(posedge sys_clk) disable iff (rst)
    sec_expired && unlock_cmd && state == ata_feat_pkg::ST_IDLE &&
    !soft_rst |=> cmd_abort ##1 sec_expired)
    else $error("unlock accepted after expiry");
  a_rot_rate: assert property (@(posedge sys_clk) disable iff (rst)
    id_out_valid && id_out_index == ata_feat_pkg::ID_WORD_ROTATION
    |-> id_out_word == ata_feat_pkg::ROTATION_NONROT)
    else $error("rotation word wrong");
  a_sec_lock: assert property (@(posedge sys_clk) disable iff (rst)
    id_valid && id_index == ata_feat_pkg::ID_WORD_SECURITY
    |=> id_out_word[3:2] == {$past(sec_state.frozen), $past(sec_state.locked)})
    else $error("security lock bits wrong");
  a_csum_sig: assert property (@(posedge sys_clk) disable iff (rst)
    id_out_valid && id_out_index == ata_feat_pkg::ID_WORD_INTEGRITY
    |-> id_out_word[7:0] == ata_feat_pkg::ID_SIGNATURE)
    else $error("integrity signature missing");

endmodule // ata_set_features

// File: hw/ata_feat_pkg.sv
// Constants and types for the set-features and identify word logic
package ata_feat_pkg;

  // ----------------------------------------------------------------
  // Command and feature codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_FEATURES = 8'hEF;
  localparam logic [7:0] FC_8BIT_ON      = 8'h01;
  localparam logic [7:0] FC_WCACHE_ON    = 8'h02;
  localparam logic [7:0] FC_XFER_MODE    = 8'h03;
  localparam logic [7:0] FC_APM_ON       = 8'h05;
  localparam logic [7:0] FC_EXTPWR_ON    = 8'h09;
  localparam logic [7:0] FC_LOOKAHEAD_OFF = 8'h55;
  localparam logic [7:0] FC_KEEP_ON_SRST = 8'h66;
  localparam logic [7:0] FC_NOP_A        = 8'h69;
  localparam logic [7:0] FC_8BIT_OFF     = 8'h81;
  localparam logic [7:0] FC_WCACHE_OFF   = 8'h82;
  localparam logic [7:0] FC_APM_OFF      = 8'h85;
  localparam logic [7:0] FC_EXTPWR_OFF   = 8'h89;
  localparam logic [7:0] FC_NOP_B        = 8'h96;
  localparam logic [7:0] FC_LEGACY       = 8'h97;
  localparam logic [7:0] FC_LOOKAHEAD_ON = 8'hAA;
  localparam logic [7:0] FC_RESTORE_SRST = 8'hCC;

  // ----------------------------------------------------------------
  // Transfer mode byte: type in [7:3], mode in [2:0]
  // ----------------------------------------------------------------
  localparam int         XFER_TYPE_LSB  = 3;
  localparam logic [4:0] XT_PIO_DEFAULT = 5'h00;
  localparam logic [4:0] XT_PIO_FLOW    = 5'h01;
  localparam logic [4:0] XT_MWDMA       = 5'h04;
  localparam logic [4:0] XT_UDMA        = 5'h08;
  localparam logic [2:0] MODE_DEFAULT   = 3'h0;
  localparam logic [2:0] MODE_NO_IORDY  = 3'h1;

  // ----------------------------------------------------------------
  // Identify words and security status bit positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  ID_WORD_SECURITY  = 8'h80;
  localparam logic [7:0]  ID_WORD_ROTATION  = 8'hD9;
  localparam logic [7:0]  ID_WORD_INTEGRITY = 8'hFF;
  localparam logic [7:0]  ID_WORD_FIRST     = 8'h00;
  localparam logic [15:0] ROTATION_NONROT   = 16'h0001;
  localparam logic [7:0]  ID_SIGNATURE      = 8'hA5;
  localparam int SEC_BIT_SUPPORT = 0;
  localparam int SEC_BIT_ENABLED = 1;
  localparam int SEC_BIT_LOCKED  = 2;
  localparam int SEC_BIT_FROZEN  = 3;
  localparam int SEC_BIT_EXPIRED = 4;
  localparam int SEC_BIT_ENH     = 5;
  localparam int SEC_BIT_LEVEL   = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_FLUSH = 2'b10
  } state_e;

  typedef enum logic [1:0] {
    DMA_NONE  = 2'h0,
    DMA_MWDMA = 2'h1,
    DMA_UDMA  = 2'h2
  } dma_kind_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] feature;
    logic [7:0] count;
  } cmd_s;

  typedef struct packed {
    logic      eight_bit;
    logic      write_cache;
    logic      apm;
    logic      ext_power;
    logic      read_ahead;
    logic      keep_on_srst;
    logic      iordy_off;
    logic [2:0] pio_mode;
    dma_kind_e dma_kind;
    logic [2:0] dma_mode;
  } cfg_s;

  typedef struct packed {
    logic supported;
    logic enabled;
    logic locked;
    logic frozen;
    logic level_max;
    logic enh_erase;
  } sec_s;

  // Power-on defaults: read look-ahead off, PIO default mode
  localparam cfg_s CFG_POR = '{
    eight_bit:    1'b0,
    write_cache:  1'b0,
    apm:          1'b0,
    ext_power:    1'b0,
    read_ahead:   1'b0,
    keep_on_srst: 1'b0,
    iordy_off:    1'b0,
    pio_mode:     3'h0,
    dma_kind:     DMA_NONE,
    dma_mode:     3'h0
  };

endpackage

// File: hw/idw_checksum.sv
// Running byte sum over identify words for the integrity word
`timescale 1ns/10ps
module idw_checksum (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        word_valid,
  input  wire logic [7:0]  word_index,
  input  wire logic [15:0] word_data,
  output logic      [7:0]  csum
);

  logic [7:0] sum;
  logic [7:0] word_bytes;

  assign word_bytes = word_data[7:0] + word_data[15:8];
  // Sum plus signature plus csum wraps to zero
  assign csum = 8'h00 - (sum + ata_feat_pkg::ID_SIGNATURE);

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  // Word 0 restarts the sum so a re-read needs no clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sum <= 8'h00;
    end else if (word_valid) begin
      if (word_index == ata_feat_pkg::ID_WORD_FIRST) begin
        sum <= word_bytes;
      end else if (word_index != ata_feat_pkg::ID_WORD_INTEGRITY) begin
        sum <= sum + word_bytes;
      end
    end
  end

endmodule // idw_checksum

// File: bench/host_model.sv
// Host controller model: task-file commands, soft reset, identify sum
`timescale 1ns/10ps
module host_model (
  input  wire logic          sys_clk,
  input  wire logic          id_out_valid,
  input  wire logic [7:0]    id_out_index,
  input  wire logic [15:0]   id_out_word,
  output logic               soft_rst,
  output logic               cmd_valid,
  output ata_feat_pkg::cmd_s cmd,
  output logic [7:0]         id_sum
);
  initial begin
    soft_rst = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
  end

  task automatic send(input logic [7:0] op, input logic [7:0] f,
                      input logic [7:0] n);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd = '{opcode: op, feature: f, count: n};
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    // Released task file must not look like a held command
    cmd = ~cmd;
    // Returns while the one-cycle answer pulse still stands
  endtask

  task automatic srst();
    @(negedge sys_clk);
    soft_rst = 1'b1;
    @(negedge sys_clk);
    soft_rst = 1'b0;
    @(negedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    if (id_out_valid) begin
      id_sum <= (id_out_index == 8'h00 ? 8'h00 : id_sum)
                + id_out_word[15:8] + id_out_word[7:0];
    end
  end
endmodule // host_model

// File: bench/ata_set_features_tb.sv
// Self-checking bench for the set-features and identify logic
`timescale 1ns/10ps
module ata_set_features_tb;
  localparam logic [3:0] TRIES = 4'h5;
  logic               sys_clk, rst, soft_rst, cmd_valid, flush_ack;
  logic               unlock_fail, unlock_cmd, erase_cmd, id_valid;
  logic               busy, cmd_done, cmd_abort, err_abrt, flush_req;
  logic               iocs16_en, sec_expired, id_out_valid;
  logic [7:0]         id_index, id_out_index, id_sum;
  logic [15:0]        id_word, id_out_word, w128, w217, w255;
  ata_feat_pkg::cmd_s cmd;
  ata_feat_pkg::sec_s sec_state;
  ata_feat_pkg::cfg_s cfg, exp;
  int                 err_count, n_tests;
  logic [7:0]         fon [8] = '{8'h02, 8'h05, 8'h09, 8'hAA, 8'h66,
                                  8'h69, 8'h96, 8'h97};
  logic [7:0]         foff [5] = '{8'h81, 8'h85, 8'h89, 8'h55, 8'hCC};
  logic [7:0]         xm [9] = '{8'h00, 8'h01, 8'h0C, 8'h22, 8'h46,
                                 8'h0D, 8'h23, 8'h47, 8'h10};

  ata_set_features #(.UNLOCK_TRIES(TRIES)) dut (
    .sys_clk(sys_clk), .rst(rst), .soft_rst(soft_rst), .cmd(cmd),
    .cmd_valid(cmd_valid), .flush_ack(flush_ack), .sec_state(sec_state),
    .unlock_fail(unlock_fail), .unlock_cmd(unlock_cmd),
    .erase_cmd(erase_cmd), .id_valid(id_valid), .id_index(id_index),
    .id_word(id_word), .busy(busy), .cmd_done(cmd_done),
    .cmd_abort(cmd_abort), .err_abrt(err_abrt), .flush_req(flush_req),
    .cfg(cfg), .iocs16_en(iocs16_en), .sec_expired(sec_expired),
    .id_out_valid(id_out_valid), .id_out_index(id_out_index),
    .id_out_word(id_out_word));

  host_model host (
    .sys_clk(sys_clk), .id_out_valid(id_out_valid),
    .id_out_index(id_out_index), .id_out_word(id_out_word),
    .soft_rst(soft_rst), .cmd_valid(cmd_valid), .cmd(cmd), .id_sum(id_sum));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (id_out_valid && id_out_index == 8'h80) w128 <= id_out_word;
    if (id_out_valid && id_out_index == 8'hD9) w217 <= id_out_word;
    if (id_out_valid && id_out_index == 8'hFF) w255 <= id_out_word;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want,
                     input string what);
    n_tests++;
    if (got !== want) begin
      err_count++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  // Expected settings after a successful command
  function automatic ata_feat_pkg::cfg_s nxt(ata_feat_pkg::cfg_s c,
                                             logic [7:0] f, logic [7:0] n);
    case (f)
      8'h01: c.eight_bit = 1'b1;
      8'h81: c.eight_bit = 1'b0;
      8'h02: c.write_cache = 1'b1;
      8'h82: c.write_cache = 1'b0;
      8'h05: c.apm = 1'b1;
      8'h85: c.apm = 1'b0;
      8'h09: c.ext_power = 1'b1;
      8'h89: c.ext_power = 1'b0;
      8'hAA: c.read_ahead = 1'b1;
      8'h55: c.read_ahead = 1'b0;
      8'h66: c.keep_on_srst = 1'b1;
      8'hCC: c.keep_on_srst = 1'b0;
      8'h03: case (n[7:3])
        5'h04, 5'h08: begin
          c.dma_kind = n[6] ? ata_feat_pkg::DMA_UDMA : ata_feat_pkg::DMA_MWDMA;
          c.dma_mode = n[2:0];
        end
        default: begin
          c.iordy_off = n[0] & ~n[3];
          c.pio_mode = n[3] ? n[2:0] : 3'h0;
        end
      endcase
      default: ;
    endcase
    return c;
  endfunction

  task automatic feat(input logic [7:0] f, input logic [7:0] n,
                      input logic ok);
    host.send(ata_feat_pkg::OP_SET_FEATURES, f, n);
    if (ok) exp = nxt(exp, f, n);
    chk({cmd_done, cmd_abort, err_abrt}, {ok, !ok, !ok}, "answer");
    chk(cfg, exp, "cfg");
  endtask

  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask

  task automatic scan();
    for (int i = 0; i < 256; i++) begin
      @(negedge sys_clk);
      id_valid = 1'b1;
      id_index = i[7:0];
      id_word = (i == 255) ? 16'h00A5 : {i[7:0], 8'h3C};
    end
    @(negedge sys_clk);
    id_valid = 1'b0;
    @(negedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {flush_ack, unlock_fail, unlock_cmd, erase_cmd, id_valid} = 5'h00;
    id_index = 8'h00;
    id_word = 16'h0000;
    sec_state = 6'h37;
    err_count = 0;
    n_tests = 0;
    exp = ata_feat_pkg::CFG_POR;
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk({cfg, iocs16_en}, {exp, 1'b1}, "reset");
    host.send(8'hE3, 8'h01, 8'h00);
    chk({cmd_done, cmd_abort}, 2'h0, "other opcode");
    feat(8'h01, 8'h00, 1'b1);
    chk(iocs16_en, 1'b0, "8-bit");
    foreach (fon[i]) feat(fon[i], 8'h00, 1'b1);
    host.send(ata_feat_pkg::OP_SET_FEATURES, 8'h82, 8'h00);
    chk({busy, flush_req, cfg.write_cache}, 3'h6, "flush");
    repeat (3) @(negedge sys_clk);
    chk({busy, cmd_done}, 2'h2, "flush wait");
    flush_ack = 1'b1;
    @(negedge sys_clk);
    flush_ack = 1'b0;
    chk({busy, flush_req, cmd_done}, 3'h1, "flush end");
    exp.write_cache = 1'b0;
    foreach (foff[i]) feat(foff[i], 8'h00, 1'b1);
    chk(iocs16_en, 1'b1, "16-bit");
    $display("feature test done");
    for (int i = 0; i < 9; i++) feat(8'h03, xm[i], i < 5);
    feat(8'h00, 8'h00, 1'b0);
    host.srst();
    chk(cfg, ata_feat_pkg::CFG_POR, "srst");
    chk(err_abrt, 1'b0, "srst err");
    exp = ata_feat_pkg::CFG_POR;
    feat(8'h66, 8'h00, 1'b1);
    feat(8'h01, 8'h00, 1'b1);
    host.srst();
    chk(cfg, exp, "srst keep");
    $display("mode and reset test done");
    scan();
    chk(w128, 16'h012B, "security");
    chk(w217, 16'h0001, "rotation");
    chk({id_sum, w255[7:0]}, 16'h00A5, "integrity");
    pulse(unlock_cmd);
    chk(cmd_abort, 1'b0, "early unlock");
    for (int i = 1; i <= TRIES; i++) begin
      pulse(unlock_fail);
      chk(sec_expired, i == TRIES, "expiry");
    end
    pulse(unlock_cmd);
    chk({cmd_abort, err_abrt}, 2'h3, "unlock blocked");
    pulse(erase_cmd);
    chk({cmd_abort, err_abrt}, 2'h3, "erase blocked");
    host.srst();
    chk(sec_expired, 1'b1, "expiry kept");
    sec_state = 6'h2A;
    scan();
    chk(w128, 16'h0015, "security");
    chk(id_sum, 8'h00, "integrity");
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    chk({sec_expired, cfg}, {1'b0, ata_feat_pkg::CFG_POR}, "hard rst");
    $display("identify test done");
    report_and_stop;
  end

  initial begin
    repeat (4000) @(posedge sys_clk);
    err_count++;
    report_and_stop;
  end
endmodule // ata_set_features_tb
